// File: rtl/sound_mixer_level.sv
// address latch, register storage, noise source, mixers and level select
// the host reaches everything through two strobes and one data byte
// all derived outputs are registered; all but NOISE_O sit one clock behind the store
module sound_mixer_level
  import sound_mix_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic ADDR_WR_I,
  input wire logic DATA_WR_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  input wire logic [2:0] TONE_I,
  input wire logic [3:0] ENVELOPE_LEVEL_I,
  output logic [11:0] TONE_PERIOD_A_O,
  output logic [11:0] TONE_PERIOD_B_O,
  output logic [11:0] TONE_PERIOD_C_O,
  output logic NOISE_O,
  output logic [2:0] MIX_O,
  output logic [3:0] LEVEL_A_O,
  output logic [3:0] LEVEL_B_O,
  output logic [3:0] LEVEL_C_O,
  output logic [2:0] CHANNEL_ON_O,
  output logic PORT_A_OUT_O,
  output logic PORT_B_OUT_O
);
  import sound_mix_pkg::*;

  // host side: register carrier and latched register number
  sound_reg_if rif ();
  logic [3:0] addr_reg;

  // noise side: prescaler, period counter and shift register
  logic [3:0] prescale_reg;
  logic prescale_done;
  logic [4:0] noise_cnt_reg;
  logic noise_step;
  logic [16:0] lfsr_reg;
  logic [4:0] noise_period_value;

  // mixer and level side
  logic [7:0] mixer_reg;
  logic [2:0] noise_en;
  logic [2:0] tone_en;
  logic [2:0] mix_next;
  logic [7:0] lvl [0:2];

  // ****************************************************
  // host access
  // ****************************************************
  // address latch
  // both strobes in one clock: the write still goes to the old register number
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      addr_reg <= 4'h0;
    else if (ADDR_WR_I)
      addr_reg <= DATA_I[3:0];
  end

  // each data write uses the latched address
  // no write bypasses the latch, so every change needs its own sequence
  // read data come from the store's flip-flop, never straight from the inputs
  assign rif.wr_en = DATA_WR_I;
  assign rif.wr_addr = addr_reg;
  assign rif.wr_data = DATA_I;
  assign rif.rd_addr = addr_reg;
  assign DATA_O = rif.rd_data;

  // all sixteen bytes are kept, so every register reads back as written
  sound_reg_file u_regs (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .bus(rif.owner)
  );

  // ****************************************************
  // tone periods
  // ****************************************************
  // low four coarse bits times 256 plus fine
  // coarse and fine arrive in separate writes,
  // so the period shows one old half and one new half between them
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      TONE_PERIOD_A_O <= 12'h000;
      TONE_PERIOD_B_O <= 12'h000;
      TONE_PERIOD_C_O <= 12'h000;
    end
    else
    begin
      TONE_PERIOD_A_O <= tone_period_value(rif.regs[1], rif.regs[0]);
      TONE_PERIOD_B_O <= tone_period_value(rif.regs[3], rif.regs[2]);
      TONE_PERIOD_C_O <= tone_period_value(rif.regs[5], rif.regs[4]);
    end
  end

  // ****************************************************
  // noise source
  // ****************************************************
  // low five bits only
  // upper three bits never reach the divider
  assign noise_period_value = rif.regs[NOISE_PERIOD_ADDR][NOISE_PERIOD_MSB:0];

  // divide clock by sixteen first
  // free running; its phase is not tied to host writes
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      prescale_reg <= 4'h0;
    else
      prescale_reg <= prescale_reg + 4'h1;
  end

  // one strobe per sixteen clocks feeds the period divider
  assign prescale_done = (prescale_reg == PRESCALE_LAST);

  // period n divides by n; zero is treated as one
  // comparing with >= lets a period lowered mid-count take effect at once
  // the counter never passes thirty, so the sum cannot wrap
  assign noise_step = prescale_done && ((noise_cnt_reg + 5'h01) >= noise_period_value);

  // period counter restarts on every step
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      noise_cnt_reg <= 5'h00;
    else if (noise_step)
      noise_cnt_reg <= 5'h00;
    else if (prescale_done)
      noise_cnt_reg <= noise_cnt_reg + 5'h01;
  end

  // shift register steps once per divided period
  // the seed is non-zero so the register can never lock up at all zeros
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      lfsr_reg <= NOISE_SEED;
    else if (noise_step)
      lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[3], lfsr_reg[16:1]};
  end
  // noise comes straight from a flip-flop, so it never glitches
  assign NOISE_O = lfsr_reg[0];

  // ****************************************************
  // mixers and port direction
  // ****************************************************
  // enable bits are read straight from the store, no second copy
  assign mixer_reg = rif.regs[MIXER_ENABLE_ADDR];
  assign noise_en = ~mixer_reg[NOISE_EN_LSB +: 3];
  assign tone_en = ~mixer_reg[TONE_EN_LSB +: 3];
  // disabled source reads high, so both off gives constant high
  // that high lets the amplitude stage alone decide a muted channel's output
  assign mix_next = (TONE_I | ~tone_en) & ({3{lfsr_reg[0]}} | ~noise_en);

  // registered mixer outputs keep glitches away from the level stage
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      MIX_O <= 3'h0;
    else
      MIX_O <= mix_next;
  end

  // direction bits, one is output
  // port B has no pins in this system; its bit is still passed on
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      PORT_A_OUT_O <= 1'b0;
      PORT_B_OUT_O <= 1'b0;
    end
    else
    begin
      PORT_A_OUT_O <= mixer_reg[PORT_A_DIR_BIT];
      PORT_B_OUT_O <= mixer_reg[PORT_B_DIR_BIT];
    end
  end

  // ****************************************************
  // amplitude selection
  // ****************************************************
  // one register per channel, bits above four ignored
  // upper three bits are forced to zero so they can never reach a decision
  assign lvl[0] = {3'h0, rif.regs[CHAN_A_LEVEL_ADDR][4:0]};
  assign lvl[1] = {3'h0, rif.regs[CHAN_B_LEVEL_ADDR][4:0]};
  assign lvl[2] = {3'h0, rif.regs[CHAN_C_LEVEL_ADDR][4:0]};

  // mode bit picks source; fixed bits; envelope level
  // the envelope is taken as it stands, with one clock of delay
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      LEVEL_A_O <= 4'h0;
      LEVEL_B_O <= 4'h0;
      LEVEL_C_O <= 4'h0;
    end
    else
    begin
      LEVEL_A_O <= channel_level(lvl[0], ENVELOPE_LEVEL_I);
      LEVEL_B_O <= channel_level(lvl[1], ENVELOPE_LEVEL_I);
      LEVEL_C_O <= channel_level(lvl[2], ENVELOPE_LEVEL_I);
    end
  end

  // only the all-zero code turns a channel off
  // mixer enables play no part here: a muted mixer still drives a level
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      CHANNEL_ON_O <= 3'h0;
    else
    begin
      for (int c = 0; c < 3; c++)
        CHANNEL_ON_O[c] <= (lvl[c][4:0] != 5'h00);
    end
  end
endmodule

// File: rtl/sound_mix_pkg.sv
package sound_mix_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [3:0] REG_COUNT = 4'hF;
  localparam logic [3:0] NOISE_PERIOD_ADDR = 4'h6;
  localparam logic [3:0] MIXER_ENABLE_ADDR = 4'h7;
  localparam logic [3:0] CHAN_A_LEVEL_ADDR = 4'h8;
  localparam logic [3:0] CHAN_B_LEVEL_ADDR = 4'h9;
  localparam logic [3:0] CHAN_C_LEVEL_ADDR = 4'hA;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int NOISE_PERIOD_MSB = 4;
  localparam int NOISE_EN_LSB = 3;
  localparam int TONE_EN_LSB = 0;
  localparam int PORT_A_DIR_BIT = 6;
  localparam int PORT_B_DIR_BIT = 7;
  localparam int LEVEL_MODE_BIT = 4;
  localparam int COARSE_SHIFT = 8;
  // ****************************************************
  // timing counts
  // ****************************************************
  localparam logic [3:0] PRESCALE_LAST = 4'hF;  // divide by sixteen
  localparam logic [16:0] NOISE_SEED = 17'h00001;
  // ****************************************************
  // shared helpers
  // ****************************************************
  function automatic logic [11:0] tone_period_value(input logic [7:0] coarse_tune_value,
                                                    input logic [7:0] fine_tune_value);
    tone_period_value = {coarse_tune_value[3:0], fine_tune_value};
  endfunction
  function automatic logic [3:0] channel_level(input logic [7:0] level_reg,
                                               input logic [3:0] envelope_level_bits);
    channel_level = level_reg[LEVEL_MODE_BIT] ? envelope_level_bits : level_reg[3:0];
  endfunction
endpackage

// File: rtl/sound_reg_if.sv
// register file carrier between host access logic and the storage
interface sound_reg_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] regs [0:15];
  modport owner (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data, output regs);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data, input regs);
endinterface

// File: rtl/sound_reg_file.sv
// sixteen byte control store, registered read port
module sound_reg_file
  import sound_mix_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  sound_reg_if.owner bus
);
  // ****************************************************
  // storage
  // ****************************************************
  // data write
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < 16; i++)
        bus.regs[i] <= REG_RESET;
    end
    else if (bus.wr_en)
    begin
      bus.regs[bus.wr_addr] <= bus.wr_data;
    end
  end
  // registered read keeps read data glitch free
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      bus.rd_data <= REG_RESET;
    else
      bus.rd_data <= bus.regs[bus.rd_addr];
  end
endmodule

// File: dv/sound_mixer_level_properties.sv
module sound_mixer_level_properties (
  input logic CLK_I,
  input logic SRST_I,
  input logic ADDR_WR_I,
  input logic DATA_WR_I,
  input logic [7:0] DATA_I,
  input logic [7:0] DATA_O,
  input logic [2:0] TONE_I,
  input logic [3:0] ENVELOPE_LEVEL_I,
  input logic [11:0] TONE_PERIOD_A_O,
  input logic NOISE_O,
  input logic [2:0] MIX_O,
  input logic [3:0] LEVEL_A_O,
  input logic [3:0] LEVEL_B_O,
  input logic [3:0] LEVEL_C_O,
  input logic [2:0] CHANNEL_ON_O,
  input logic PORT_A_OUT_O,
  input logic PORT_B_OUT_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] a_q;
  logic [7:0] m_q [0:15];
  logic [7:0] m7, m8, m9, m10;
  // ****************
  // register shadow
  // ****************
  // shadow follows host writes; a same-edge write uses the old address
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      a_q <= 4'h0;
      for (int i = 0; i < 16; i++) m_q[i] <= 8'h00;
    end
    else
    begin
      if (ADDR_WR_I) a_q <= DATA_I[3:0];
      if (DATA_WR_I) m_q[a_q] <= DATA_I;
    end
  end
  assign m7 = m_q[7];
  assign m8 = m_q[8];
  assign m9 = m_q[9];
  assign m10 = m_q[10];
  function automatic logic [3:0] lv(input logic [7:0] r, input logic [3:0] e);
    return r[4] ? e : r[3:0];
  endfunction
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // minimum noise step is sixteen clocks
  sequence quiet8;
    $stable(NOISE_O)[*8];
  endsequence
  level_pick_a: assert property (
    {LEVEL_C_O, LEVEL_B_O, LEVEL_A_O} == {lv($past(m10), $past(ENVELOPE_LEVEL_I)),
    lv($past(m9), $past(ENVELOPE_LEVEL_I)), lv($past(m8), $past(ENVELOPE_LEVEL_I))})
    else $error("channel level wrong");
  chan_on_a: assert property (
    CHANNEL_ON_O == {|$past(m10[4:0]), |$past(m9[4:0]), |$past(m8[4:0])})
    else $error("channel on flag wrong");
  mix_tone_a: assert property (
    &$past(m7[5:3]) |-> MIX_O == ($past(TONE_I) | $past(m7[2:0])))
    else $error("tone gating wrong");
  mix_off_a: assert property (
    $past(m7[3]) && $past(m7[0]) |-> MIX_O[0]) else $error("disabled mix not high");
  mix_noise_a: assert property (
    !$past(m7[3]) && $past(m7[0]) |-> MIX_O[0] == $past(NOISE_O))
    else $error("noise gating wrong");
  port_dir_a: assert property (
    {PORT_B_OUT_O, PORT_A_OUT_O} == $past(m7[7:6])) else $error("port direction wrong");
  tone_per_a: assert property (
    TONE_PERIOD_A_O == {$past(m_q[1][3:0]), $past(m_q[0])}) else $error("tone period wrong");
  read_back_a: assert property (
    DATA_O == $past(m_q[a_q])) else $error("read data wrong");
  noise_hold_a: assert property (
    $changed(NOISE_O) |=> quiet8) else $error("noise stepped too soon");
endmodule
bind sound_mixer_level sound_mixer_level_properties i_props (.CLK_I, .SRST_I, .ADDR_WR_I,
  .DATA_WR_I, .DATA_I, .DATA_O, .TONE_I, .ENVELOPE_LEVEL_I, .TONE_PERIOD_A_O, .NOISE_O,
  .MIX_O, .LEVEL_A_O, .LEVEL_B_O, .LEVEL_C_O, .CHANNEL_ON_O, .PORT_A_OUT_O, .PORT_B_OUT_O);

// File: dv/host_model.sv
module host_model (
  input logic clk,
  output logic addr_wr,
  output logic data_wr,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr_wr = 1'b0;
    data_wr = 1'b0;
    data = 8'h00;
  end
  // latch then write
  // released bus shows inverted data after the write; during the gap only the upper four address bits are flipped
  task automatic put(input logic [3:0] a, input logic [7:0] d, input int gap);
    @(posedge clk);
    addr_wr <= 1'b1;
    data <= {4'h0, a};
    repeat (gap)
    begin
      @(posedge clk);
      addr_wr <= 1'b0;
      data <= 8'hF0 ^ {4'h0, a};
    end
    @(posedge clk);
    addr_wr <= 1'b0;
    data_wr <= 1'b1;
    data <= d;
    @(posedge clk);
    data_wr <= 1'b0;
    data <= ~d;
  endtask
endmodule

// File: dv/sound_mixer_level_tb.sv
module sound_mixer_level_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sound_mix_pkg::*;
  logic clk, srst, noise, pao, pbo;
  logic [2:0] tone, mix, on;
  logic [3:0] env, lev_a, lev_b, lev_c;
  logic [7:0] dout;
  logic [11:0] tpa, tpb, tpc;
  wire addr_wr, data_wr;
  wire [7:0] din;
  int regs [16];
  int num_errors = 0;
  int compares = 0;
  host_model i_host_model (.clk(clk), .addr_wr(addr_wr), .data_wr(data_wr), .data(din));
  sound_mixer_level i_sound_mixer_level (.CLK_I(clk), .SRST_I(srst), .ADDR_WR_I(addr_wr),
    .DATA_WR_I(data_wr), .DATA_I(din), .DATA_O(dout), .TONE_I(tone),
    .ENVELOPE_LEVEL_I(env), .TONE_PERIOD_A_O(tpa), .TONE_PERIOD_B_O(tpb),
    .TONE_PERIOD_C_O(tpc), .NOISE_O(noise), .MIX_O(mix), .LEVEL_A_O(lev_a),
    .LEVEL_B_O(lev_b), .LEVEL_C_O(lev_c), .CHANNEL_ON_O(on), .PORT_A_OUT_O(pao),
    .PORT_B_OUT_O(pbo));
  // ****************
  // checks
  // ****************
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic int lvl(int r);
    return (r & 16) ? int'(env) : (r & 15);
  endfunction
  task automatic check_all(input int a);
    int c_on;
    c_on = 0;
    for (int c = 0; c < 3; c++) if (regs[8 + c] & 31) c_on |= 1 << c;
    chk("level_a", lvl(regs[8]), lev_a);
    chk("level_b", lvl(regs[9]), lev_b);
    chk("level_c", lvl(regs[10]), lev_c);
    chk("chan_on", c_on, on);
    chk("read", regs[a], dout);
    chk("tone_a", (regs[1] & 15) * 256 + regs[0], tpa);
    chk("tone_b", (regs[3] & 15) * 256 + regs[2], tpb);
    chk("tone_c", (regs[5] & 15) * 256 + regs[4], tpc);
    chk("ports", regs[7] >> 6, {pbo, pao});
    for (int c = 0; c < 3; c++)
      if ((regs[7] >> (3 + c)) & 1) chk("mix", tone[c] | ((regs[7] >> c) & 1), mix[c]);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    logic [3:0] a;
    logic [7:0] d;
    logic old;
    int t;
    srst = 1'b1;
    tone = 3'h0;
    env = 4'h0;
    void'($urandom(32'hB6D0));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 check_all(0);
    $display("test reset done");
    for (int n = 0; n < 80; n++)
    begin
      a = 4'($urandom_range(15));
      d = 8'($urandom);
      if (n < 8) {a, d} = {4'h7, 2'(n), 3'h7, 3'(n)};
      if (n % 5 == 0) d = d & 8'hE0;
      @(posedge clk);
      tone <= 3'($urandom);
      env <= 4'($urandom);
      i_host_model.put(a, d, n % 3);
      regs[a] = int'(d);
      @(posedge clk);
      #1 check_all(int'(a));
    end
    $display("test registers done");
    // noise alone on channel A, tone only on B and C, while gaps are timed
    i_host_model.put(4'h7, 8'h31, 1);
    regs[7] = 32'h31;
    @(posedge clk);
    #1 check_all(7);
    for (int k = 0; k < 2; k++)
    begin
      d = k ? 8'hFF : 8'h01;
      i_host_model.put(4'h6, d, 0);
      for (int s = 0; s < 5; s++)
      begin
        t = 0;
        old = noise;
        while (noise === old && t < 9000)
        begin
          @(posedge clk);
          #1 t++;
        end
        if (s > 1) chk("noise_gap", 0, (t % (k ? 496 : 16)) + (t >= 9000));
      end
    end
    $display("test noise done");
    print_verdict();
  end
endmodule
